// ### stp_cpu_model.sv
`timescale 1ns/10ps
// CPU side of the trap handshake: ends each hardware service after dly_i cycles.
module stp_cpu_model (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Trap handshake.
   input wire logic take_i,
   input wire logic busy_i,
   input wire logic [7:0] dly_i,
   output logic done_o
);
   logic [7:0] cnt_q; // Cycles left in the current service.
   // A new hardware take restarts the count, as a preempting service would.
   // Done is held back on a take edge, so a preempted service ends the new one only when that take rises on the edge that sets done.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 8'h00;
         done_o <= 1'b0;
      end else begin
         done_o <= (cnt_q == 8'h01) && !take_i;
         if (take_i && busy_i) begin
            cnt_q <= dly_i;
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule : stp_cpu_model

// ### stp_if.sv
`timescale 1ns/10ps
// Register traffic between the bus front end and the two engines.
interface stp_if;
   logic [3:0] sv_wr;
   logic tfr_wr;
   logic [15:0] wdata;
   logic [15:0] wmask;
   logic [15:0] sv_reg [0:3];
   logic [15:0] trap_flag_register;
   modport host (output sv_wr, tfr_wr, wdata, wmask, input sv_reg, trap_flag_register);
   modport mux (input sv_wr, wdata, wmask, output sv_reg);
   modport trap (input tfr_wr, wdata, wmask, output trap_flag_register);
endinterface : stp_if

// ### stp_pkg.sv
// Notes on behaviour
// - Four shared vectors, enable high byte, flags low
// - Enable bit masks a source onto its vector
// - Flag sets on event even when masked
// - Two-wire, serial ports routed to vectors 0-2
// - CAN, PWM to 3 too; errors, unlock 3
// - Resets: vector 0, number 0, top priority
// - Class A traps: own vectors, below resets
// - Class B traps share vector 28h, lower
// - Reset or hardware trap forces level 15
// - Each hardware trap sets its flag bit
// - Hardware trap preempts unless same or higher class runs
package stp_pkg;
   // ----------------------------------------
   // Register byte addresses.
   // ----------------------------------------
   localparam logic [7:0] ADR_SV0 = 8'h00;
   localparam logic [7:0] ADR_SV3 = 8'h0C;
   localparam logic [7:0] ADR_TFR = 8'h10;
   localparam logic [7:0] ADR_IST = 8'h14;
   localparam logic [7:0] ADR_IMSK = 8'h18;
   localparam logic [15:0] SV_RST = 16'h0000;
   localparam logic [15:0] TFR_RST = 16'h0000;
   localparam logic [4:0] IRQ_RST = 5'h00;
   // ----------------------------------------
   // Source indices and routing.
   // ----------------------------------------
   localparam int NSRC = 14;
   localparam logic [3:0] S_NONE = 4'hF;
   // Per vector, per flag bit, which source feeds it; S_NONE is empty.
   localparam logic [3:0] SV_ROUTE [0:3][0:7] = '{
      '{4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA},
      '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA},
      '{4'hD, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA},
      '{4'h0, 4'h1, 4'h4, 4'h7, 4'hB, 4'hC, 4'hD, 4'hF}};
   // ----------------------------------------
   // Trap numbers; vector location is number times four.
   // ----------------------------------------
   localparam logic [7:0] TN_RESET = 8'h00;
   localparam logic [7:0] TN_NMI = 8'h02;
   localparam logic [7:0] TN_STACK_OVERFLOW_FLAG = 8'h04;
   localparam logic [7:0] TN_STACK_UNDERFLOW_FLAG = 8'h06;
   localparam logic [7:0] TN_CLSB = 8'h0A;
   localparam logic [3:0] ILVL_MAX = 4'hF;
   // Trap flag bits: 0-2 class A, 3-8 class B.
   localparam int TF_B0 = 3;
   // Service states, one-hot.
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CLSB = 4'b0010,
      ST_CLSA = 4'b0100,
      ST_RST = 4'b1000
   } stp_state_t;
endpackage : stp_pkg

// ### stp_shared_mux.sv
`timescale 1ns/10ps
// Four shared vectors, each with eight enable and eight flag bits.
module stp_shared_mux (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [13:0] src_evt_i,
   input wire logic hold_i,
   stp_if.mux rif,
   output logic [3:0] sv_req_o
);
   import stp_pkg::*;
   // Event vector with a constant zero slot for empty positions.
   logic [15:0] evt;
   assign evt = {2'b00, src_evt_i};
   genvar v;
   generate
      for (v = 0; v < 4; v++) begin : g_vec
         logic [7:0] en_q;
         logic [7:0] fl_q;
         logic [7:0] hit;
         // Gather this vector's source events through the routing table.
         always_comb begin
            for (int k = 0; k < 8; k++) begin
               hit[k] = (SV_ROUTE[v][k] == S_NONE) ? 1'b0 : evt[SV_ROUTE[v][k]];
            end
         end
         // Enables follow software writes byte by byte.
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               en_q <= SV_RST[15:8];
            end else if (rif.sv_wr[v]) begin
               en_q <= (en_q & ~rif.wmask[15:8]) | (rif.wdata[15:8] & rif.wmask[15:8]);
            end
         end
         // Flags set regardless of enable; a written zero clears, a new event wins.
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               fl_q <= SV_RST[7:0];
            end else if (rif.sv_wr[v]) begin
               fl_q <= (fl_q & ~(rif.wmask[7:0] & ~rif.wdata[7:0])) | hit;
            end else begin
               fl_q <= fl_q | hit;
            end
         end
         assign rif.sv_reg[v] = {en_q, fl_q};
         // Request is held off while a hardware trap is being serviced.
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               sv_req_o[v] <= 1'b0;
            end else begin
               sv_req_o[v] <= (|(fl_q & en_q)) & ~hold_i;
            end
         end
      end
   endgenerate
endmodule : stp_shared_mux

// ### stp_top.sv
`timescale 1ns/10ps
module stp_top (
   // Clock and reset.
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // Wishbone slave.
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // Peripheral event pulses.
   input wire logic [13:0] SRC_EVT_I,
   // Exception sources and CPU status.
   input wire logic [1:0] RESET_EVT_I,
   input wire logic [2:0] CLASS_A_I,
   input wire logic [5:0] CLASS_B_I,
   input wire logic SW_TRAP_I,
   input wire logic [6:0] SW_TRAP_NUM_I,
   input wire logic [3:0] CPU_ILVL_I,
   input wire logic TRAP_DONE_I,
   // Requests towards the CPU.
   output logic [3:0] SV_REQ_O,
   output logic TRAP_TAKE_O,
   output logic [23:0] TRAP_VEC_O,
   output logic [7:0] TRAP_NUM_O,
   output logic [3:0] TRAP_ILVL_O,
   output logic TRAP_BUSY_O,
   output logic IRQ_O
);
   import stp_pkg::*;

   // ----------------------------------------
   // Internal nets.
   // ----------------------------------------
   stp_if rif (); // Register traffic to the engines.
   logic req; // A bus request waits for its answer.
   logic wr; // Write accepted this cycle.
   logic [15:0] bmask; // Byte lanes as a bit mask.
   logic ack_q; // Bus acknowledge.
   logic [31:0] dat_q; // Read data.
   logic [3:0] sv_req; // Vector requests from the mux.
   logic [3:0] sv_prev_q; // Last cycle's vector requests.
   logic take; // Exception launch pulse.
   logic busy; // Hardware trap in service.
   logic [4:0] ist_q; // Sticky event status.
   logic [4:0] imsk_q; // Interrupt mask.
   logic [4:0] ev; // Event pulses into the status.
   logic irq_q; // Interrupt output flop.
   logic [31:0] rd; // Read value before registering.

   // ----------------------------------------
   // Bus decode.
   // ----------------------------------------
   // One request per ack; the answer comes one edge after the request.
   assign req = CYC_I & STB_I & ~ack_q;
   assign wr = req & WE_I;
   assign bmask = {{8{SEL_I[1]}}, {8{SEL_I[0]}}};
   assign rif.wdata = DAT_I[15:0];
   assign rif.wmask = bmask;
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_wr
         // Each select register sits on its own aligned word.
         assign rif.sv_wr[i] = wr && (ADR_I == ADR_SV0 + 8'(4 * i));
      end
   endgenerate
   assign rif.tfr_wr = wr && (ADR_I == ADR_TFR);

   // Read mux; unmapped words and unused upper bits read as zero.
   always_comb begin
      rd = 32'h0000_0000;
      case (ADR_I)
         ADR_SV0: rd = {16'h0000, rif.sv_reg[0]};
         ADR_SV0 + 8'h04: rd = {16'h0000, rif.sv_reg[1]};
         ADR_SV0 + 8'h08: rd = {16'h0000, rif.sv_reg[2]};
         ADR_SV3: rd = {16'h0000, rif.sv_reg[3]};
         ADR_TFR: rd = {16'h0000, rif.trap_flag_register};
         ADR_IST: rd = {27'h000_0000, ist_q};
         ADR_IMSK: rd = {27'h000_0000, imsk_q};
         default: rd = 32'h0000_0000;
      endcase
   end

   // Acknowledge every request, mapped or not, so the master never hangs.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // Capture read data at the same edge the ack rises.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         dat_q <= 32'h0000_0000;
      end else if (req && !WE_I) begin
         dat_q <= rd;
      end
   end

   // ----------------------------------------
   // Engines.
   // ----------------------------------------
   stp_shared_mux u_mux (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .src_evt_i(SRC_EVT_I),
      .hold_i(busy),
      .rif(rif.mux),
      .sv_req_o(sv_req)
   );

   stp_trap_prio u_trap (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .rst_evt_i(RESET_EVT_I),
      .cls_a_i(CLASS_A_I),
      .cls_b_i(CLASS_B_I),
      .sw_trap_i(SW_TRAP_I),
      .sw_num_i(SW_TRAP_NUM_I),
      .cpu_ilvl_i(CPU_ILVL_I),
      .done_i(TRAP_DONE_I),
      .rif(rif.trap),
      .take_o(take),
      .vec_o(TRAP_VEC_O),
      .num_o(TRAP_NUM_O),
      .ilvl_o(TRAP_ILVL_O),
      .busy_o(busy)
   );

   // ----------------------------------------
   // Interrupt status and mask.
   // ----------------------------------------
   // Events: rising edge of each vector request, and any exception launch.
   assign ev = {take, sv_req & ~sv_prev_q};

   // Remember requests to find their rising edges.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         sv_prev_q <= 4'h0;
      end else begin
         sv_prev_q <= sv_req;
      end
   end

   // Write one to clear; an event in the same cycle keeps its bit set.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ist_q <= IRQ_RST;
      end else if (wr && ADR_I == ADR_IST && SEL_I[0]) begin
         ist_q <= (ist_q & ~DAT_I[4:0]) | ev;
      end else begin
         ist_q <= ist_q | ev;
      end
   end

   // Mask register, plain read and write.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         imsk_q <= IRQ_RST;
      end else if (wr && ADR_I == ADR_IMSK && SEL_I[0]) begin
         imsk_q <= DAT_I[4:0];
      end
   end

   // Level interrupt, one cycle behind the status so it leaves a flop.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ist_q & imsk_q);
      end
   end

   // ----------------------------------------
   // Outputs.
   // ----------------------------------------
   // All of these come from flops in this module or the engines.
   assign ACK_O = ack_q;
   assign DAT_O = dat_q;
   assign SV_REQ_O = sv_req;
   assign TRAP_TAKE_O = take;
   assign TRAP_BUSY_O = busy;
   assign IRQ_O = irq_q;
endmodule : stp_top

// ### stp_top_asserts.sv
`timescale 1ns/10ps
// Port-level checks of the bus, the shared vectors and the trap arbiter.
module stp_chk (
   // Clock, reset and inputs.
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic TRAP_DONE_I,
   input wire logic [1:0] RESET_EVT_I,
   // Outputs.
   input wire logic [31:0] DAT_O,
   input wire logic ACK_O,
   input wire logic [3:0] SV_REQ_O,
   input wire logic TRAP_TAKE_O,
   input wire logic [23:0] TRAP_VEC_O,
   input wire logic [7:0] TRAP_NUM_O,
   input wire logic [3:0] TRAP_ILVL_O,
   input wire logic TRAP_BUSY_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   a_ack_follows_req: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("request not acknowledged next cycle");
   a_ack_one_cycle: assert property (ACK_O |=> !ACK_O)
      else $error("ack held beyond one cycle");
   a_read_data_holds: assert property (!(CYC_I && STB_I && !WE_I && !ACK_O) |=> $stable(DAT_O))
      else $error("read data changed without a read");
   a_req_gated_busy: assert property (TRAP_BUSY_O && $past(TRAP_BUSY_O) |-> SV_REQ_O == 4'h0)
      else $error("shared vector request during trap service");
   a_hw_level_forced: assert property (TRAP_TAKE_O && TRAP_BUSY_O |-> TRAP_ILVL_O == 4'hF)
      else $error("hardware trap level not forced to fifteen");
   a_vec_num_scaled: assert property (TRAP_TAKE_O |-> TRAP_VEC_O == {14'h0000, TRAP_NUM_O, 2'b00})
      else $error("vector location is not four times the number");
   a_busy_until_done: assert property (TRAP_BUSY_O && !TRAP_DONE_I |=> TRAP_BUSY_O)
      else $error("trap service ended without done");
   a_reset_evt_wins: assert property ((RESET_EVT_I != 2'h0) && !TRAP_BUSY_O && !$past(RST_I)
      && $past(RESET_EVT_I) == 2'h0 && $past(RESET_EVT_I, 2) == 2'h0
      |-> ##2 (TRAP_TAKE_O && TRAP_NUM_O == 8'h00 && TRAP_ILVL_O == 4'hF))
      else $error("reset event not taken two cycles later");
endmodule : stp_chk
bind stp_top stp_chk chk_u (.CLOCK_I, .RST_I, .CYC_I, .STB_I, .WE_I, .TRAP_DONE_I,
   .RESET_EVT_I, .DAT_O, .ACK_O, .SV_REQ_O, .TRAP_TAKE_O, .TRAP_VEC_O, .TRAP_NUM_O,
   .TRAP_ILVL_O, .TRAP_BUSY_O);

// ### stp_trap_prio.sv
`timescale 1ns/10ps
// Exception arbiter: resets, class A, class B and software traps.
module stp_trap_prio (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] rst_evt_i,
   input wire logic [2:0] cls_a_i,
   input wire logic [5:0] cls_b_i,
   input wire logic sw_trap_i,
   input wire logic [6:0] sw_num_i,
   input wire logic [3:0] cpu_ilvl_i,
   input wire logic done_i,
   stp_if.trap rif,
   output logic take_o,
   output logic [23:0] vec_o,
   output logic [7:0] num_o,
   output logic [3:0] ilvl_o,
   output logic busy_o
);
   import stp_pkg::*;
   stp_state_t state_q;
   logic p_rst_q;
   logic [2:0] p_a_q;
   logic p_b_q;
   logic p_sw_q;
   logic [6:0] sw_num_q;
   logic [15:0] tfr_q;
   logic go_rst, go_a, go_b, go_sw;
   // Admission: a trap enters only above the class in service.
   always_comb begin
      go_rst = p_rst_q && (state_q != ST_RST);
      go_a = !go_rst && (|p_a_q) && (state_q == ST_IDLE || state_q == ST_CLSB);
      go_b = !go_rst && !(|p_a_q) && p_b_q && (state_q == ST_IDLE);
      go_sw = p_sw_q && !p_rst_q && !(|p_a_q) && !p_b_q && (state_q == ST_IDLE);
   end
   // Pending latches; hardware reset leaves a reset service pending.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p_rst_q <= 1'b1;
         p_a_q <= 3'b000;
         p_b_q <= 1'b0;
         p_sw_q <= 1'b0;
         sw_num_q <= 7'h00;
      end else begin
         p_rst_q <= (p_rst_q & ~go_rst) | (|rst_evt_i);
         p_a_q <= (go_a ? (p_a_q & (p_a_q - 3'd1)) : p_a_q) | cls_a_i;
         p_b_q <= (p_b_q & ~go_b) | (|cls_b_i);
         if (sw_trap_i && !p_sw_q) begin
            p_sw_q <= 1'b1;
            sw_num_q <= sw_num_i;
         end else if (go_sw) begin
            p_sw_q <= 1'b0;
         end
      end
   end
   // Trap flags: events set, software writing zero clears, set wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tfr_q <= TFR_RST;
      end else if (rif.tfr_wr) begin
         tfr_q <= (tfr_q & ~(rif.wmask & ~rif.wdata)) | {7'h00, cls_b_i, cls_a_i};
      end else begin
         tfr_q <= tfr_q | {7'h00, cls_b_i, cls_a_i};
      end
   end
   assign rif.trap_flag_register = tfr_q;
   // Service launch; lowest set class A bit is the highest ranked.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         take_o <= 1'b0;
         num_o <= TN_RESET;
         ilvl_o <= 4'h0;
         busy_o <= 1'b0;
      end else begin
         take_o <= go_rst | go_a | go_b | go_sw;
         // Busy is kept in its own flop, mirroring the state, so the top output leaves a flop.
         if (go_rst) begin
            state_q <= ST_RST;
            busy_o <= 1'b1;
            num_o <= TN_RESET;
            ilvl_o <= ILVL_MAX;
         end else if (go_a) begin
            state_q <= ST_CLSA;
            busy_o <= 1'b1;
            num_o <= p_a_q[0] ? TN_NMI : (p_a_q[1] ? TN_STACK_OVERFLOW_FLAG : TN_STACK_UNDERFLOW_FLAG);
            ilvl_o <= ILVL_MAX;
         end else if (go_b) begin
            state_q <= ST_CLSB;
            busy_o <= 1'b1;
            num_o <= TN_CLSB;
            ilvl_o <= ILVL_MAX;
         end else if (go_sw) begin
            num_o <= {1'b0, sw_num_q};
            ilvl_o <= cpu_ilvl_i;
         end else if (done_i) begin
            state_q <= ST_IDLE;
            busy_o <= 1'b0;
         end
      end
   end
   assign vec_o = {14'h0000, num_o, 2'b00};
endmodule : stp_trap_prio

// ### tb_shared_irq_mux_and_trap_priority.sv
`timescale 1ns/10ps
// Self-checking bench: registers, routing, interrupt line and trap order.
module tb_shared_irq_mux_and_trap_priority;
   import stp_pkg::*;
   logic CLOCK_I, RST_I, CYC_I, STB_I, WE_I, SW_TRAP_I, TRAP_DONE_I, ACK_O, TRAP_TAKE_O;
   logic TRAP_BUSY_O, IRQ_O;
   logic [7:0] ADR_I, TRAP_NUM_O, dly, en [4];
   logic [3:0] SEL_I, CPU_ILVL_I, SV_REQ_O, TRAP_ILVL_O, er, lvl;
   logic [31:0] DAT_I, DAT_O;
   logic [13:0] SRC_EVT_I;
   logic [1:0] RESET_EVT_I;
   logic [2:0] CLASS_A_I;
   logic [5:0] CLASS_B_I;
   logic [6:0] SW_TRAP_NUM_I, num;
   logic [23:0] TRAP_VEC_O;
   logic [15:0] rd;
   logic [12:0] tq [$]; // Takes seen, as {busy, level, number}.
   logic [23:0] vq [$]; // Vector locations seen with each take.
   int err_total, num_checks, cyc_n;
   // Source index in each flag slot; 99 marks an empty slot.
   int slots [4][8] = '{'{0, 2, 3, 5, 6, 8, 9, 10}, '{1, 2, 3, 5, 6, 8, 9, 10},
      '{13, 2, 3, 5, 6, 8, 9, 10}, '{0, 1, 4, 7, 11, 12, 13, 99}};
   stp_top dut_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
      .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
      .ACK_O(ACK_O), .SRC_EVT_I(SRC_EVT_I), .RESET_EVT_I(RESET_EVT_I),
      .CLASS_A_I(CLASS_A_I), .CLASS_B_I(CLASS_B_I), .SW_TRAP_I(SW_TRAP_I),
      .SW_TRAP_NUM_I(SW_TRAP_NUM_I), .CPU_ILVL_I(CPU_ILVL_I), .TRAP_DONE_I(TRAP_DONE_I),
      .SV_REQ_O(SV_REQ_O), .TRAP_TAKE_O(TRAP_TAKE_O), .TRAP_VEC_O(TRAP_VEC_O),
      .TRAP_NUM_O(TRAP_NUM_O), .TRAP_ILVL_O(TRAP_ILVL_O), .TRAP_BUSY_O(TRAP_BUSY_O),
      .IRQ_O(IRQ_O));
   stp_cpu_model cpu_u (.clk_i(CLOCK_I), .rst_i(RST_I), .take_i(TRAP_TAKE_O),
      .busy_i(TRAP_BUSY_O), .dly_i(dly), .done_o(TRAP_DONE_I));
   initial begin
      CLOCK_I = 1'b0;
      forever #12.5 CLOCK_I = ~CLOCK_I;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // The ceiling is over twenty times the expected run, so only a hang reaches it.
   always @(posedge CLOCK_I) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         err_total++;
         end_sim();
      end
   end
   // Every take is queued so that the order of services can be judged.
   always @(posedge CLOCK_I) begin
      if (TRAP_TAKE_O === 1'b1) begin
         tq.push_back({TRAP_BUSY_O, TRAP_ILVL_O, TRAP_NUM_O});
         vq.push_back(TRAP_VEC_O);
      end
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One classic cycle; the request is held until ack is sampled high.
   task automatic wb(logic w, logic [7:0] a, logic [15:0] d);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I <= w;
      ADR_I <= a;
      DAT_I <= {16'h0000, d};
      SEL_I <= 4'h3;
      @(posedge CLOCK_I);
      while (ACK_O !== 1'b1) @(posedge CLOCK_I);
      rd = DAT_O[15:0];
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      @(posedge CLOCK_I);
   endtask : wb
   task automatic take_chk(logic [12:0] e);
      for (int n = 0; n < 300 && tq.size() == 0; n++) @(posedge CLOCK_I);
      chk("trap take", 32'(e), (tq.size() > 0) ? 32'(tq.pop_front()) : 32'hFFFF_FFFF);
      chk("trap vector", 32'({e[7:0], 2'b00}), (vq.size() > 0) ? 32'(vq.pop_front()) : 32'hFFFF_FFFF);
   endtask : take_chk
   task automatic pulse(logic [13:0] s, logic [1:0] r, logic [2:0] a, logic [5:0] b, logic w);
      SRC_EVT_I <= s;
      RESET_EVT_I <= r;
      CLASS_A_I <= a;
      CLASS_B_I <= b;
      SW_TRAP_I <= w;
      @(posedge CLOCK_I);
      {SRC_EVT_I, RESET_EVT_I, CLASS_A_I, CLASS_B_I, SW_TRAP_I} <= '0;
   endtask : pulse
   task automatic idle;
      for (int n = 0; n < 300 && TRAP_BUSY_O !== 1'b0; n++) @(posedge CLOCK_I);
   endtask : idle
   function automatic logic [7:0] flg(int v, int s);
      flg = 8'h00;
      for (int b = 0; b < 8; b++) if (slots[v][b] == s) flg[b] = 1'b1;
   endfunction : flg
   initial begin
      {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I, SW_TRAP_NUM_I, CPU_ILVL_I} = '0;
      {SRC_EVT_I, RESET_EVT_I, CLASS_A_I, CLASS_B_I, SW_TRAP_I} = '0;
      RST_I = 1'b1;
      dly = 8'h04;
      void'($urandom(32'hf9a0));
      repeat (20) @(posedge CLOCK_I);
      RST_I <= 1'b0;
      take_chk({1'b1, 4'hF, 8'h00});
      idle();
      for (int v = 0; v < 5; v++) begin
         wb(1'b0, 8'(v * 4), 16'h0000);
         chk("reset value", 32'h0, 32'(rd));
      end
      wb(1'b1, 8'h40, 16'hFFFF);
      wb(1'b0, 8'h40, 16'h0000);
      chk("unmapped read", 32'h0, 32'(rd));
      for (int s = 0; s < 14; s++) begin
         for (int v = 0; v < 4; v++) begin
            en[v] = (s == 0) ? 8'hFF : 8'($urandom);
            er[v] = |(flg(v, s) & en[v]);
            wb(1'b1, 8'(v * 4), {en[v], 8'h00});
         end
         pulse(14'h0001 << s, 2'h0, 3'h0, 6'h00, 1'b0);
         repeat (2) @(posedge CLOCK_I);
         chk("vector requests", 32'(er), 32'(SV_REQ_O));
         for (int v = 0; v < 4; v++) begin
            wb(1'b0, 8'(v * 4), 16'h0000);
            chk("mask and flags", 32'({en[v], flg(v, s)}), 32'(rd));
         end
      end
      wb(1'b1, ADR_IST, 16'h001F);
      wb(1'b1, ADR_SV3, 16'hFF00);
      pulse(14'h1000, 2'h0, 3'h0, 6'h00, 1'b0);
      repeat (4) @(posedge CLOCK_I);
      chk("irq masked", 32'h0, 32'(IRQ_O));
      wb(1'b1, ADR_IMSK, 16'h0008);
      @(posedge CLOCK_I);
      chk("irq raised", 32'h1, 32'(IRQ_O));
      wb(1'b1, ADR_IST, 16'h0008);
      @(posedge CLOCK_I);
      chk("irq cleared", 32'h0, 32'(IRQ_O));
      // Each exception alone: resets, then class A, then class B.
      for (int i = 0; i < 11; i++) begin
         pulse(14'h0000, 2'(i < 2 ? 1 << i : 0), 3'(i >= 2 && i < 5 ? 1 << (i - 2) : 0),
            6'(i >= 5 ? 1 << (i - 5) : 0), 1'b0);
         take_chk({1'b1, 4'hF, 8'(i < 2 ? 0 : (i < 5 ? 2 * (i - 1) : 10))});
         wb(1'b0, ADR_TFR, 16'h0000);
         chk("trap flags", 32'(i < 2 ? 0 : 1 << (i - 2)), 32'(rd));
         wb(1'b1, ADR_TFR, 16'h0000);
         idle();
      end
      // A slow core lets later events queue up or preempt.
      dly = 8'h1E;
      pulse(14'h0000, 2'h0, 3'h4, 6'h01, 1'b0);
      take_chk({1'b1, 4'hF, 8'h06});
      take_chk({1'b1, 4'hF, 8'h0A});
      pulse(14'h0000, 2'h0, 3'h1, 6'h00, 1'b0);
      take_chk({1'b1, 4'hF, 8'h02});
      CPU_ILVL_I <= 4'h3;
      SW_TRAP_NUM_I <= 7'h55;
      pulse(14'h0000, 2'h1, 3'h0, 6'h00, 1'b1);
      take_chk({1'b1, 4'hF, 8'h00});
      take_chk({1'b0, 4'h3, 8'h55});
      dly = 8'h04;
      idle();
      for (int k = 0; k < 6; k++) begin
         num = (k == 0) ? 7'h00 : ((k == 1) ? 7'h7F : 7'($urandom));
         lvl = 4'($urandom);
         CPU_ILVL_I <= lvl;
         SW_TRAP_NUM_I <= num;
         pulse(14'h0000, 2'h0, 3'h0, 6'h00, 1'b1);
         take_chk({1'b0, lvl, 1'b0, num});
      end
      end_sim();
   end
endmodule : tb_shared_irq_mux_and_trap_priority
